/* File: verilog/umna_pkg.sv */
// Constants and types shared by the multi-node serial port files.
// The core runs from one synchronous system clock.
package umna_pkg;
  // ==========================================================
  // Register byte addresses on the plain register port
  localparam logic [11:0] ADDR_DATA = 12'hF40;
  localparam logic [11:0] ADDR_STAT0 = 12'hF41;
  localparam logic [11:0] ADDR_CTL0 = 12'hF42;
  localparam logic [11:0] ADDR_CTL1 = 12'hF43;
  localparam logic [11:0] ADDR_STAT1 = 12'hF44;
  localparam logic [11:0] ADDR_NODE = 12'hF45;
  localparam logic [11:0] ADDR_DIV_HI = 12'hF46;
  localparam logic [11:0] ADDR_DIV_LO = 12'hF47;
  // ==========================================================
  // Field positions
  localparam int CTL0_TX_EN = 7;
  localparam int CTL0_RX_EN = 6;
  localparam int CTL0_IR_EN = 0;
  localparam int CTL1_MODE_LO = 0;
  localparam int CTL1_MODE_HI = 1;
  localparam int CTL1_MP_EN = 2;
  localparam int CTL1_TIMER = 3;
  localparam int CTL1_TX_MPB = 4;
  localparam int STAT0_RDA = 7;
  localparam int STAT0_TX_EMPTY = 6;
  localparam int STAT0_TX_BUSY = 5;
  localparam int STAT0_TIMER = 1;
  localparam int STAT1_ADDR = 0;
  localparam int STAT1_NEW_FRAME_FLAG = 1;
  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0010;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [2:0] TX_LAST_BIT = 3'h7;
  localparam logic [3:0] RX_BITS_PLAIN = 4'h8;
  localparam logic [3:0] RX_BITS_MP = 4'h9;
  // ==========================================================
  // State encodings
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_MPB = 3'b011,
    TX_STOP = 3'b100
  } umna_tx_state_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10,
    RX_STOP = 2'b11
  } umna_rx_state_type;
endpackage : umna_pkg

/* File: verilog/umna_divider.sv */
// Reloading down counter behind the bit rate and the interval timer.
// Assumes the divisor is stable while the counter runs.
`timescale 1ns/1ns
`default_nettype none
module umna_divider
  import umna_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [15:0] i_div,
  output logic o_tick,
  output logic [15:0] o_count
);
  logic [15:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // ==========================================================
  // One tick every i_div cycles; a zero divisor acts as one
  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q;
    if (!i_run) begin
      cnt_d = i_div;
    end else if (cnt_q <= CNT_ONE) begin
      tick_d = 1'b1;
      cnt_d = i_div;
    end else begin
      cnt_d = cnt_q - CNT_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q <= RST_DIVISOR;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
  assign o_count = cnt_q;
endmodule : umna_divider
`default_nettype wire

/* File: verilog/umna_core.sv */
// Multi-node serial port: address filtering, driver enable, timer, IR path.
// Register port is synchronous to I_CLK_SYS; serial inputs are synchronous.
//
// Overview of operation
// R01: Four filter modes, active only with enable
// R02: Mode 01 interrupts on address bytes only
// R03: Mode 00: every byte interrupts
// R04: Flag bytes that start a frame
// R05: Software sets mode bit0 on foreign frame
// R06: Mode 10 drops mismatched address frames
// R07: Mode 10 matched frame: address and data interrupt
// R08: First accepted data byte flags new frame
// R09: Each address byte is compared again
// R10: Mode 11 filters, no address byte interrupt
// R11: Modes 10 and 11 deliver only matched frames
// R12: Node address register, 8 bits, resets zero
// R13: Driver enable spans whole transmitted frame
// R14: Two bytes form sixteen-bit rate divisor
// R15: Software disables port before timer use
// R16: Timer period is divisor clock periods
// R17: IR enable routes serial data through codec
// R18: Ninth bit marks address characters
// R19: Driver enable drops after last stop
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module umna_core
  import umna_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic [11:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_RXD,
  input wire logic I_IR_RX,
  output logic O_TXD,
  output logic O_IR_TX,
  output logic O_DE,
  output logic O_RX_IRQ,
  output logic O_TIMER_IRQ
);
  // ==========================================================
  // Declarations
  logic [7:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d, node_q, node_d, rdata_q, rdata_d;
  logic [15:0] div_q, div_d;
  logic [7:0] rxbuf_q, rxbuf_d;
  logic rda_q, rda_d, addrf_q, addrf_d, new_frame_flag_q, new_frame_flag_d, tmrf_q, tmrf_d;
  logic match_q, match_d, first_q, first_d, irq_q, irq_d;
  logic [8:0] txbuf_q, txbuf_d, txsh_q, txsh_d;
  logic txfull_q, txfull_d;
  umna_tx_state_type tx_q, tx_d;
  logic [2:0] txn_q, txn_d;
  logic txd_q, txd_d, irtx_q, irtx_d, de_q, de_d, tirq_q, tirq_d;
  umna_rx_state_type rx_q, rx_d;
  logic [15:0] rxc_q, rxc_d, irs_q, irs_d;
  logic [3:0] rxn_q, rxn_d;
  logic [8:0] rxsh_q, rxsh_d;
  logic tick, tx_line, rx_line, rx_done, is_addr, deliver, irq_now, nf_now;
  logic [15:0] dcount;
  logic [1:0] mode;
  logic mp_en, timer_mode, ir_en, load_tx;
  logic [7:0] rx_byte;

  assign mode = ctl1_q[CTL1_MODE_HI:CTL1_MODE_LO];
  assign mp_en = ctl1_q[CTL1_MP_EN];
  assign timer_mode = ctl1_q[CTL1_TIMER];
  assign ir_en = ctl0_q[CTL0_IR_EN];

  // Three quarters of a bit; long enough to cover the mid-bit sample
  function automatic logic [15:0] three_quarter(input logic [15:0] d);
    three_quarter = d - (d >> 2);
  endfunction : three_quarter

  // ==========================================================
  // Shared divider: bit clock for transmit, interval for timer mode
  umna_divider u_div (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_run((tx_q != TX_IDLE) || timer_mode), // R16
    .i_div(div_q), // R14
    .o_tick(tick),
    .o_count(dcount)
  );

  // ==========================================================
  // Receive filter decision for a completed character
  always_comb begin
    is_addr = mp_en & rxsh_q[8]; // R18
    rx_byte = mp_en ? rxsh_q[7:0] : rxsh_q[8:1];
    deliver = 1'b1;
    irq_now = 1'b1;
    nf_now = 1'b0;
    match_d = match_q;
    first_d = first_q;
    if (rx_done && mp_en) begin // R01
      if (!mode[1]) begin
        irq_now = is_addr | ~mode[0]; // R02 R03
      end else if (is_addr) begin
        match_d = (rx_byte == node_q); // R09
        first_d = (rx_byte == node_q);
        deliver = (rx_byte == node_q) & ~mode[0]; // R06 R10
        irq_now = deliver; // R07
      end else begin
        deliver = match_q; // R11
        irq_now = match_q; // R07
        nf_now = match_q & first_q; // R08
        first_d = 1'b0;
      end
    end
  end

  // ==========================================================
  // Register file; hardware sets win over software clears
  always_comb begin
    ctl0_d = ctl0_q;
    ctl1_d = ctl1_q;
    node_d = node_q;
    div_d = div_q;
    txbuf_d = txbuf_q;
    txfull_d = txfull_q & ~load_tx;
    rda_d = rda_q;
    tmrf_d = tmrf_q;
    rxbuf_d = rxbuf_q;
    addrf_d = addrf_q;
    new_frame_flag_d = new_frame_flag_q;
    irq_d = 1'b0;
    rdata_d = RST_BYTE;
    if (I_WR) begin
      case (I_ADDR)
        ADDR_DATA: begin
          // Writes to a full buffer are dropped, not queued
          if (!txfull_q) begin
            txbuf_d = {ctl1_q[CTL1_TX_MPB], I_WDATA};
            txfull_d = 1'b1;
          end
        end
        ADDR_CTL0: ctl0_d = I_WDATA;
        ADDR_CTL1: ctl1_d = I_WDATA;
        ADDR_NODE: node_d = I_WDATA; // R12
        ADDR_DIV_HI: div_d = {I_WDATA, div_q[7:0]}; // R14
        ADDR_DIV_LO: div_d = {div_q[15:8], I_WDATA};
        default: ;
      endcase
    end
    if (I_RD) begin
      case (I_ADDR)
        ADDR_DATA: begin
          rdata_d = rxbuf_q;
          rda_d = 1'b0;
        end
        ADDR_STAT0: begin
          rdata_d[STAT0_RDA] = rda_q;
          rdata_d[STAT0_TX_EMPTY] = ~txfull_q;
          rdata_d[STAT0_TX_BUSY] = (tx_q != TX_IDLE);
          rdata_d[STAT0_TIMER] = tmrf_q;
          tmrf_d = 1'b0;
        end
        ADDR_CTL0: rdata_d = ctl0_q;
        ADDR_CTL1: rdata_d = ctl1_q;
        ADDR_STAT1: begin
          rdata_d[STAT1_ADDR] = addrf_q;
          rdata_d[STAT1_NEW_FRAME_FLAG] = new_frame_flag_q;
        end
        ADDR_NODE: rdata_d = node_q;
        ADDR_DIV_HI: rdata_d = div_q[15:8];
        ADDR_DIV_LO: rdata_d = div_q[7:0];
        default: rdata_d = RST_BYTE;
      endcase
    end
    if (tick && timer_mode) begin
      tmrf_d = 1'b1; // R16
    end
    tirq_d = tick & timer_mode;
    if (rx_done && deliver) begin
      rxbuf_d = rx_byte;
      rda_d = 1'b1; // R11
      addrf_d = is_addr; // R04
      new_frame_flag_d = nf_now; // R08
      irq_d = irq_now;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      ctl0_q <= RST_BYTE;
      ctl1_q <= RST_BYTE;
      node_q <= RST_BYTE;
      div_q <= RST_DIVISOR;
      txbuf_q <= 9'h000;
      txfull_q <= 1'b0;
      rda_q <= 1'b0;
      tmrf_q <= 1'b0;
      rxbuf_q <= RST_BYTE;
      addrf_q <= 1'b0;
      new_frame_flag_q <= 1'b0;
      match_q <= 1'b0;
      first_q <= 1'b0;
      irq_q <= 1'b0;
      tirq_q <= 1'b0;
      rdata_q <= RST_BYTE;
    end else begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
      node_q <= node_d;
      div_q <= div_d;
      txbuf_q <= txbuf_d;
      txfull_q <= txfull_d;
      rda_q <= rda_d;
      tmrf_q <= tmrf_d;
      rxbuf_q <= rxbuf_d;
      addrf_q <= addrf_d;
      new_frame_flag_q <= new_frame_flag_d;
      match_q <= match_d;
      first_q <= first_d;
      irq_q <= irq_d;
      tirq_q <= tirq_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Transmitter; a queued byte follows the stop bit with no idle gap
  always_comb begin
    tx_d = tx_q;
    txsh_d = txsh_q;
    txn_d = txn_q;
    load_tx = 1'b0;
    tx_line = 1'b1;
    unique case (tx_q)
      TX_IDLE: begin
        if (txfull_q && ctl0_q[CTL0_TX_EN]) begin
          load_tx = 1'b1;
          txsh_d = txbuf_q;
          tx_d = TX_START;
        end
      end
      TX_START: begin
        tx_line = 1'b0;
        txn_d = 3'h0;
        if (tick) tx_d = TX_DATA;
      end
      TX_DATA: begin
        tx_line = txsh_q[0];
        if (tick) begin
          txsh_d = {txsh_q[8], txsh_q[8:1]};
          txn_d = txn_q + 3'h1;
          if (txn_q == TX_LAST_BIT) tx_d = mp_en ? TX_MPB : TX_STOP;
        end
      end
      TX_MPB: begin
        tx_line = txsh_q[8]; // R18
        if (tick) tx_d = TX_STOP;
      end
      TX_STOP: begin
        if (tick) begin
          if (txfull_q && ctl0_q[CTL0_TX_EN]) begin
            load_tx = 1'b1;
            txsh_d = txbuf_q;
            tx_d = TX_START;
          end else begin
            tx_d = TX_IDLE; // R19
          end
        end
      end
      default: tx_d = TX_IDLE;
    endcase
    de_d = (tx_q != TX_IDLE); // R13
    txd_d = ir_en ? 1'b1 : tx_line; // R17
    // The tick cycle still belongs to the old bit; pulsing there would add a late pulse
    irtx_d = ir_en && !tx_line && !tick && (dcount > three_quarter(div_q)); // R17
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      tx_q <= TX_IDLE;
      txsh_q <= 9'h1FF;
      txn_q <= 3'h0;
      de_q <= 1'b0;
      txd_q <= 1'b1;
      irtx_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      txsh_q <= txsh_d;
      txn_q <= txn_d;
      de_q <= de_d;
      txd_q <= txd_d;
      irtx_q <= irtx_d;
    end
  end

  // ==========================================================
  // Receiver with mid-bit sampling; bad stop bits discard the character
  always_comb begin
    rx_line = ir_en ? (irs_q == CNT_ZERO) : I_RXD; // R17
    irs_d = I_IR_RX ? three_quarter(div_q) : ((irs_q == CNT_ZERO) ? CNT_ZERO : irs_q - CNT_ONE);
    rx_d = rx_q;
    rxc_d = (rxc_q == CNT_ZERO) ? CNT_ZERO : rxc_q - CNT_ONE;
    rxn_d = rxn_q;
    rxsh_d = rxsh_q;
    rx_done = 1'b0;
    unique case (rx_q)
      RX_IDLE: begin
        if (!rx_line && ctl0_q[CTL0_RX_EN]) begin
          rx_d = RX_START;
          rxc_d = div_q >> 1;
        end
      end
      RX_START: begin
        if (rxc_q == CNT_ZERO) begin
          rx_d = rx_line ? RX_IDLE : RX_BITS;
          rxc_d = div_q;
          rxn_d = 4'h0;
        end
      end
      RX_BITS: begin
        if (rxc_q == CNT_ZERO) begin
          rxsh_d = {rx_line, rxsh_q[8:1]};
          rxn_d = rxn_q + 4'h1;
          rxc_d = div_q;
          if (rxn_q + 4'h1 == (mp_en ? RX_BITS_MP : RX_BITS_PLAIN)) rx_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rxc_q == CNT_ZERO) begin
          rx_done = rx_line;
          rx_d = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      rx_q <= RX_IDLE;
      rxc_q <= CNT_ZERO;
      rxn_q <= 4'h0;
      rxsh_q <= 9'h000;
      irs_q <= CNT_ZERO;
    end else begin
      rx_q <= rx_d;
      rxc_q <= rxc_d;
      rxn_q <= rxn_d;
      rxsh_q <= rxsh_d;
      irs_q <= irs_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_TXD = txd_q;
  assign O_IR_TX = irtx_q;
  assign O_DE = de_q;
  assign O_RX_IRQ = irq_q;
  assign O_TIMER_IRQ = tirq_q;

  // ==========================================================
  // Checks; gap counter measures timer spacing
  logic [15:0] gap_q;
  logic gapv_q;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET || !timer_mode || div_d != div_q) begin
      gap_q <= CNT_ZERO;
      gapv_q <= 1'b0;
    end else begin
      gap_q <= tick ? CNT_ZERO : gap_q + CNT_ONE;
      gapv_q <= gapv_q | tick;
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  a_timer_period: assert property (tick && gapv_q && div_q > CNT_ZERO |-> gap_q + CNT_ONE == div_q) // R16
    else $error("timer interval differs from divisor");
  a_de_envelope: assert property (tx_q != TX_IDLE |=> O_DE) // R13
    else $error("driver enable low during frame");
  a_de_release: assert property (tx_q == TX_STOP && tick && !txfull_q |=> ##1 !O_DE) // R19
    else $error("driver enable held after last stop");
  a_mode01_data: assert property (rx_done && mp_en && mode == 2'b01 && !is_addr |=> !O_RX_IRQ) // R02
    else $error("data byte interrupted in mode 01");
  a_mode00_all: assert property (rx_done && mp_en && mode == 2'b00 |=> O_RX_IRQ && rda_q) // R03
    else $error("byte missed interrupt in mode 00");
  a_mismatch_drop: assert property (rx_done && mp_en && mode[1] && is_addr && rx_byte != node_q
                                    |=> !O_RX_IRQ ##1 (!O_RX_IRQ) [*2]) // R06
    else $error("mismatched address byte not dropped");
  a_match_irq: assert property (rx_done && mp_en && mode == 2'b10 && is_addr && rx_byte == node_q
                                |=> O_RX_IRQ && addrf_q) // R07
    else $error("matched address gave no interrupt");
  a_mode11_addr: assert property (rx_done && mp_en && mode == 2'b11 && is_addr |=> !O_RX_IRQ) // R10
    else $error("address interrupt in mode 11");
  a_first_data: assert property (rx_done && mp_en && mode[1] && !is_addr && match_q && first_q
                                 |=> new_frame_flag_q && O_RX_IRQ) // R08
    else $error("first data byte not flagged");
  a_filter_rda: assert property (rx_done && mp_en && mode[1] && !is_addr && !match_q |=> !$rose(rda_q)) // R11
    else $error("unmatched frame reached receive buffer");
  a_node_write: assert property (I_WR && I_ADDR == ADDR_NODE |=> node_q == $past(I_WDATA)) // R12
    else $error("node address write lost");

  c_tx_frame: cover property (tx_q == TX_STOP && tick ##2 !O_DE);
  c_match_frame: cover property (rx_done && mode == 2'b10 && is_addr && rx_byte == node_q);
  c_timer_tick: cover property (O_TIMER_IRQ);
  c_ir_pulse: cover property (O_IR_TX);
endmodule : umna_core
`default_nettype wire

/* File: testbench/umna_node_model.sv */
// Far-side serial node on the shared multi-drop line.
// The bench keeps the default bit times in system clock cycles: 9 per sent bit, 8 per sampled bit.
`timescale 1ns/1ns
`default_nettype none
module umna_node_model (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd,
  output logic o_ir_rx
);
  int bit_cyc = 9;
  int tx_cyc = 8;
  bit ir_on = 1'b0;
  // ==========================================================
  // Line driving
  // Idle line is high, IR pulse line idle low
  initial begin
    o_rxd = 1'b1;
    o_ir_rx = 1'b0;
  end
  // One bit for a whole bit time; in IR mode a short pulse marks a zero
  task automatic put_bit(input logic b);
    for (int i = 0; i < bit_cyc; i++) begin
      @(posedge i_clk);
      o_rxd <= ir_on | b;
      o_ir_rx <= ir_on & !b & (i < bit_cyc / 4 + 1);
    end
  endtask : put_bit
  // Start, eight data bits lsb first, optional address marker, stop
  task automatic send_char(input logic [7:0] d, input bit mp, input logic ninth);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      put_bit(d[i]);
    end
    if (mp) begin
      put_bit(ninth);
    end
    put_bit(1'b1);
  endtask : send_char
  // ==========================================================
  // Line sampling
  // Waits a bounded time for a start bit, then samples mid-bit
  task automatic get_char(output logic [7:0] d, output logic nb, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 4000 && !ok; i++) begin
      @(posedge i_clk);
      ok = (i_txd === 1'b0);
    end
    repeat (tx_cyc / 2) @(posedge i_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (tx_cyc) @(posedge i_clk);
      if (i < 8) d[i] = i_txd;
      else nb = i_txd;
    end
  endtask : get_char
endmodule : umna_node_model
`default_nettype wire

/* File: testbench/tb_uart_multinode_addressing.sv */
// Self-checking bench for the multi-node serial port core.
// Assumes the node model on the serial side; serial tests use divisor 8.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_uart_multinode_addressing
  import umna_pkg::*;
;
  logic I_CLK_SYS, I_RESET, I_WR, I_RD, I_RXD, I_IR_RX;
  logic [11:0] I_ADDR;
  logic [7:0] I_WDATA, O_RDATA, node, b, v;
  logic O_TXD, O_IR_TX, O_DE, O_RX_IRQ, O_TIMER_IRQ, ir_last, nb;
  int n_fail = 0, compares = 0, cyc = 0, irq_cnt = 0, ir_pulses = 0;
  int de_run = 0, de_len = 0, de_gap = 0, txd_low = 0, c0, t0, t1;
  bit ok;
  logic [15:0] t;
  umna_core umna_core_inst (.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_RXD(I_RXD),
    .I_IR_RX(I_IR_RX), .O_TXD(O_TXD), .O_IR_TX(O_IR_TX), .O_DE(O_DE),
    .O_RX_IRQ(O_RX_IRQ), .O_TIMER_IRQ(O_TIMER_IRQ));
  umna_node_model umna_node_model_inst (.i_clk(I_CLK_SYS), .i_txd(O_TXD), .o_rxd(I_RXD),
    .o_ir_rx(I_IR_RX));
  // ==========================================================
  // Clock and monitors; monitors sample on the falling edge to avoid races
  initial begin
    I_CLK_SYS = 1'b0;
    forever #10 I_CLK_SYS = ~I_CLK_SYS;
  end
  always @(negedge I_CLK_SYS) begin
    cyc++;
    ir_last <= O_IR_TX;
    if (O_RX_IRQ === 1'b1) irq_cnt++;
    if (O_IR_TX === 1'b1 && ir_last !== 1'b1) ir_pulses++;
    if (O_TXD === 1'b0) txd_low++;
    if (O_TXD === 1'b0 && O_DE !== 1'b1) de_gap++;
    if (O_DE === 1'b1) de_run++;
    else if (de_run != 0) begin
      de_len = de_run;
      de_run = 0;
    end
  end
  // ==========================================================
  // Register port tasks; strobes last one cycle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
    #1;
  endtask : wr
  // Read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
    #1;
    d = O_RDATA;
  endtask : rd
  task automatic wait_tick(output int at);
    at = -1;
    for (int i = 0; i < 2000 && at < 0; i++) begin
      @(posedge I_CLK_SYS);
      #1;
      if (O_TIMER_IRQ === 1'b1) at = cyc;
    end
    // A missing tick is a mismatch; the output argument is not yet copied here
    if (at < 0) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_tick
  task automatic tally_and_finish();
    if (cyc > 90000 || (t0 < 0 || t1 < 0)) n_fail++;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // Receive interrupts expected for one byte
  function automatic int exp_irq(int cfg, logic [1:0] m, bit is_a, bit stored);
    if (cfg == 4 || m == 2'b00) return 1;
    if (m == 2'b01) return is_a;
    return stored;
  endfunction : exp_irq
  // ==========================================================
  // One frame pattern per filter setting; cfg 4 sets mode bits with the enable off
  task automatic rx_run(input int cfg);
    logic [1:0] m;
    bit is_a, matched, first, stored;
    m = cfg[1:0];
    matched = 1'b0;
    first = 1'b0;
    wr(ADDR_CTL1, cfg < 4 ? {6'h01, m} : 8'h03);
    for (int k = 0; k < 8; k++) begin
      is_a = (k == 0 || k == 2 || k == 4);
      b = is_a ? (k == 2 ? node ^ 8'h5A : node) : 8'($urandom);
      if (is_a) matched = (b == node);
      if (is_a) first = 1'b1;
      stored = cfg == 4 || !m[1] || (matched && (!is_a || m == 2'b10));
      c0 = irq_cnt;
      umna_node_model_inst.send_char(b, cfg < 4, is_a);
      repeat (3) @(posedge I_CLK_SYS);
      #1;
      `CHK("rx irq", exp_irq(cfg, m, is_a, stored), irq_cnt - c0)
      rd(ADDR_STAT0, v);
      `CHK("data available", stored, v[STAT0_RDA])
      if (stored) begin
        rd(ADDR_DATA, v);
        `CHK("rx byte", b, v)
        rd(ADDR_STAT1, v);
        if (cfg < 4) `CHK("addr flag", is_a, v[STAT1_ADDR])
        if (m[1] && !is_a) `CHK("new frame", first, v[STAT1_NEW_FRAME_FLAG])
      end
      if (!is_a) first = 1'b0;
      // Software filtering: open on own address, silence on a foreign one
      if (cfg == 1 && is_a) begin
        m = matched ? 2'b00 : 2'b01;
        wr(ADDR_CTL1, {6'h01, m});
      end
    end
    $display("test rx filter %0d done", cfg);
  endtask : rx_run
  // ==========================================================
  // Main sequence
  initial begin
    t0 = 0;
    t1 = 0;
    I_RESET = 1'b1;
    I_ADDR = 12'h000;
    I_WDATA = 8'h00;
    I_WR = 1'b0;
    I_RD = 1'b0;
    c0 = $urandom(57914);
    repeat (6) @(posedge I_CLK_SYS);
    I_RESET <= 1'b0;
    @(posedge I_CLK_SYS);
    rd(ADDR_NODE, v);
    `CHK("node reset", 8'h00, v)
    rd(ADDR_DIV_LO, v);
    `CHK("div lo reset", RST_DIVISOR[7:0], v)
    rd(12'hF4F, v);
    `CHK("unmapped read", 8'h00, v)
    node = 8'($urandom % 255) + 8'h01;
    wr(ADDR_NODE, node);
    wr(ADDR_DIV_HI, 8'h00);
    wr(ADDR_DIV_LO, 8'h08);
    rd(ADDR_NODE, v);
    `CHK("node readback", node, v)
    // Read data stands for one cycle only, then the port returns to zero
    @(posedge I_CLK_SYS);
    #1;
    `CHK("rdata idle", 8'h00, O_RDATA)
    rd(ADDR_DIV_HI, v);
    `CHK("div hi readback", 8'h00, v)
    $display("test registers done");
    wr(ADDR_CTL0, 8'h40);
    for (int c = 0; c < 5; c++) rx_run(c);
    // Transmit with address marker, driver enable around the frame
    wr(ADDR_CTL0, 8'h80);
    wr(ADDR_CTL1, 8'h14);
    b = 8'($urandom);
    wr(ADDR_DATA, b);
    umna_node_model_inst.get_char(v, nb, ok);
    `CHK("tx start seen", 1'b1, ok)
    `CHK("tx byte", b, v)
    `CHK("tx marker", 1'b1, nb)
    repeat (20) @(posedge I_CLK_SYS);
    #1;
    `CHK("de span", 1'b1, de_len >= 88 && de_len <= 92)
    `CHK("de gap", 0, de_gap)
    `CHK("de idle", 1'b0, O_DE)
    $display("test transmit done");
    // IR path both ways: line stays high, zeros become pulses
    wr(ADDR_CTL0, 8'hC1);
    wr(ADDR_CTL1, 8'h00);
    c0 = ir_pulses;
    t0 = txd_low;
    b = 8'($urandom);
    wr(ADDR_DATA, b);
    repeat (100) @(posedge I_CLK_SYS);
    `CHK("ir pulses", 1 + $countones(~b), ir_pulses - c0)
    `CHK("txd quiet", t0, txd_low)
    umna_node_model_inst.ir_on = 1'b1;
    c0 = irq_cnt;
    umna_node_model_inst.send_char(~b, 1'b0, 1'b0);
    repeat (40) @(posedge I_CLK_SYS);
    `CHK("ir rx irq", 1, irq_cnt - c0)
    rd(ADDR_DATA, v);
    `CHK("ir rx byte", ~b, v)
    umna_node_model_inst.ir_on = 1'b0;
    $display("test infrared done");
    // Timer: port off, load divisor, then enable
    wr(ADDR_CTL0, 8'h00);
    t = 16'h0100 + 16'($urandom % 64);
    wr(ADDR_DIV_HI, t[15:8]);
    wr(ADDR_DIV_LO, t[7:0]);
    wr(ADDR_CTL1, 8'h08);
    wait_tick(t0);
    wait_tick(t1);
    `CHK("timer gap", t, 16'(t1 - t0))
    rd(ADDR_STAT0, v);
    `CHK("timer flag", 1'b1, v[STAT0_TIMER])
    $display("test timer done");
    tally_and_finish();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge I_CLK_SYS);
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_uart_multinode_addressing
`default_nettype wire
